//--- rtl/vec_stack_pkg.sv
package vec_stack_pkg;

  // ==========================================================
  // Memory map
  localparam logic [15:0] RAM_BASE = 16'h0060;
  localparam logic [15:0] RAM_LAST = 16'h025F;
  localparam int RAM_BYTES = 512;
  localparam logic [15:0] PAGE0_END = 16'h00FF;
  localparam int PAGE0_RAM_BYTES = 160;
  localparam logic [15:0] SP_RESET = 16'h00FF;
  localparam logic [15:0] VEC_BASE = 16'hFFDA;
  localparam logic [15:0] VEC_WR_LAST = 16'hFFFD;
  localparam logic [15:0] WDOG_ALIAS = 16'hFFFF;
  // Boot address is arbitrary; real parts hold it in flash
  localparam logic [15:0] RESET_VECTOR = 16'hC000;
  localparam logic [15:0] IDX_UPPER_FLAGS = 16'hFE06;
  localparam logic [15:0] IDX_EV_STATUS = 16'hFE10;
  localparam logic [15:0] IDX_EV_MASK = 16'hFE11;
  localparam logic [15:0] IDX_SP_HI = 16'hFE12;
  localparam logic [15:0] IDX_SP_LO = 16'hFE13;

  // ==========================================================
  // Vector table, entry 0 lowest priority
  localparam int NUM_VEC = 19;
  localparam int NUM_WR_VEC = 18;
  localparam int NUM_FLAGS = 17;
  localparam logic [4:0] TRAP_ENTRY = 5'd17;
  localparam logic [NUM_VEC-1:0][15:0] VEC_ADDR = {
    16'hFFFE, 16'hFFFC, 16'hFFFA, 16'hFFF8, 16'hFFF6,
    16'hFFF4, 16'hFFF2, 16'hFFF0,
    16'hFFEE, 16'hFFEC, 16'hFFEA,
    16'hFFE8, 16'hFFE6,
    16'hFFE4, 16'hFFE2, 16'hFFE0,
    16'hFFDE, 16'hFFDC, 16'hFFDA};

  // ==========================================================
  // Stacking
  localparam logic [2:0] INT_STACK_BYTES = 3'd5;
  localparam logic [2:0] CALL_STACK_BYTES = 3'd2;

  // ==========================================================
  // Events
  localparam int NUM_EV = 3;
  localparam int EV_WDOG = 0;
  localparam int EV_STACK_FAULT = 1;
  localparam int EV_ENTRY_DONE = 2;
  localparam int AXI_AW = 18;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    ENG_IDLE = 2'b00,
    ENG_PUSH = 2'b01,
    ENG_VEC = 2'b10
  } engState_t;

  typedef struct packed {
    logic awvalid;
    logic [AXI_AW-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [AXI_AW-1:0] araddr;
    logic rready;
  } axiIn_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axiOut_t;

  typedef struct packed {
    logic intReq;
    logic trapReq;
    logic callReq;
    logic pullReq;
    logic [15:0] pc;
    logic [7:0] x;
    logic [7:0] a;
    logic [7:0] ccr;
    logic [NUM_FLAGS-1:0] flags;
  } cpuIn_t;

  typedef struct packed {
    logic busy;
    logic vecValid;
    logic [15:0] vecAddr;
    logic [15:0] vecData;
    logic pullValid;
    logic [7:0] pullData;
  } cpuOut_t;

  typedef struct packed {
    logic [RAM_BYTES-1:0][7:0] ram;
    logic [NUM_WR_VEC-1:0][15:0] vecTable;
    logic [15:0] sp;
    logic [2:0] pendUpper;
    logic [NUM_EV-1:0] evStatus;
    logic [NUM_EV-1:0] evMask;
    logic [17:0] wdogCount;
    engState_t eng;
    logic [2:0] pushCnt;
    logic [4:0][7:0] pushQueue;
    logic intEntry;
    logic trap;
    axiOut_t axi;
    cpuOut_t cpu;
    logic irq;
    logic wdogExpired;
  } state_t;

endpackage

//--- rtl/vector_stack_unit.sv
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module vector_stack_unit #(
  parameter int WDOG_CYCLES = 262144
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input vec_stack_pkg::axiIn_t axiIn,
  output vec_stack_pkg::axiOut_t axiOut,
  input vec_stack_pkg::cpuIn_t cpuIn,
  output vec_stack_pkg::cpuOut_t cpuOut,
  output logic irq,
  output logic watchdogExpired
);
  import vec_stack_pkg::*;

  // ==========================================================
  // Reset release
  logic rstMeta_ff;
  logic rstnSync_ff;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rstMeta_ff <= 1'b0;
      rstnSync_ff <= 1'b0;
    end else begin
      rstMeta_ff <= 1'b1;
      rstnSync_ff <= rstMeta_ff;
    end
  end

  state_t st_ff;
  state_t nxt_st;
  logic [NUM_VEC-1:0] pendEntry;
  logic wrAccept;
  logic engBlocked;
  logic [15:0] wrIdx;
  logic [15:0] rdIdx;

  assign wrIdx = axiIn.awaddr[17:2];
  assign rdIdx = axiIn.araddr[17:2];

  // ==========================================================
  // Pending flag per vector entry
  genvar g;
  generate
    for (g = 0; g < NUM_VEC; g++) begin : g_pend
      if (g < NUM_FLAGS) begin : g_flag
        assign pendEntry[g] = cpuIn.flags[NUM_FLAGS-1-g];
      end else begin : g_none
        assign pendEntry[g] = 1'b0;
      end
    end
  endgenerate

  function automatic logic inRam(input logic [15:0] addr);
    inRam = (addr >= RAM_BASE) && (addr <= RAM_LAST);
  endfunction

  function automatic logic [8:0] ramIdx(input logic [15:0] addr);
    logic [15:0] off;
    off = addr - RAM_BASE;
    ramIdx = off[8:0];
  endfunction

  function automatic logic [15:0] vecValue(input state_t s, input logic [4:0] k);
    vecValue = (k == 5'd18) ? RESET_VECTOR : s.vecTable[k];
  endfunction

  // Read decode: {error, byte}
  function automatic logic [8:0] readByte(input state_t s, input logic [15:0] idx);
    logic [15:0] off;
    logic [15:0] v;
    off = idx - VEC_BASE;
    v = vecValue(s, off[5:1]);
    readByte = {1'b0, 8'h00};
    if (inRam(idx)) begin
      readByte = {1'b0, s.ram[ramIdx(idx)]};
    end else if (idx >= VEC_BASE) begin
      // Watchdog alias reads back the boot address low byte
      readByte = {1'b0, off[0] ? v[7:0] : v[15:8]};
    end else if (idx == IDX_UPPER_FLAGS) begin
      readByte = {1'b0, 5'b0, s.pendUpper};
    end else if (idx == IDX_EV_STATUS) begin
      readByte = {1'b0, 5'b0, s.evStatus};
    end else if (idx == IDX_EV_MASK) begin
      readByte = {1'b0, 5'b0, s.evMask};
    end else if (idx == IDX_SP_HI) begin
      readByte = {1'b0, s.sp[15:8]};
    end else if (idx == IDX_SP_LO) begin
      readByte = {1'b0, s.sp[7:0]};
    end else begin
      readByte = {1'b1, 8'h00};
    end
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    logic [NUM_EV-1:0] evSet;
    logic [NUM_EV-1:0] evClr;
    logic [15:0] off;
    logic [8:0] rb;
    logic [4:0] k;
    logic [15:0] pullAddr;
    evSet = '0;
    evClr = '0;
    off = wrIdx - VEC_BASE;
    rb = 9'h000;
    k = TRAP_ENTRY;
    pullAddr = st_ff.sp + 16'h0001;
    nxt_st = st_ff;
    nxt_st.axi.awready = 1'b0;
    nxt_st.axi.wready = 1'b0;
    nxt_st.axi.arready = 1'b0;
    nxt_st.cpu.vecValid = 1'b0;
    nxt_st.cpu.pullValid = 1'b0;
    nxt_st.wdogExpired = 1'b0;
    nxt_st.pendUpper = cpuIn.flags[16:14];

    if (st_ff.wdogCount == 18'(WDOG_CYCLES - 1)) begin
      nxt_st.wdogCount = '0;
      nxt_st.wdogExpired = 1'b1;
      evSet[EV_WDOG] = 1'b1;
    end else begin
      nxt_st.wdogCount = st_ff.wdogCount + 18'd1;
    end

    // Writes wait for an idle stacking engine so RAM has one writer
    wrAccept = axiIn.awvalid && axiIn.wvalid && !st_ff.axi.awready && !st_ff.axi.bvalid &&
               st_ff.eng == ENG_IDLE;
    engBlocked = wrAccept || st_ff.axi.awready;
    if (wrAccept) begin
      nxt_st.axi.awready = 1'b1;
      nxt_st.axi.wready = 1'b1;
    end
    if (st_ff.axi.bvalid && axiIn.bready) begin
      nxt_st.axi.bvalid = 1'b0;
    end
    if (st_ff.axi.awready) begin
      nxt_st.axi.bvalid = 1'b1;
      nxt_st.axi.bresp = RESP_OKAY;
      if (inRam(wrIdx)) begin
        if (axiIn.wstrb[0]) begin
          nxt_st.ram[ramIdx(wrIdx)] = axiIn.wdata[7:0];
        end
      end else if (wrIdx >= VEC_BASE && wrIdx <= VEC_WR_LAST) begin
        if (axiIn.wstrb[0] && off[0]) begin
          nxt_st.vecTable[off[5:1]][7:0] = axiIn.wdata[7:0];
        end else if (axiIn.wstrb[0]) begin
          nxt_st.vecTable[off[5:1]][15:8] = axiIn.wdata[7:0];
        end
      end else if (wrIdx == WDOG_ALIAS) begin
        nxt_st.wdogCount = '0;
      end else if (wrIdx == IDX_EV_STATUS) begin
        evClr = axiIn.wstrb[0] ? axiIn.wdata[NUM_EV-1:0] : '0;
      end else if (wrIdx == IDX_EV_MASK) begin
        if (axiIn.wstrb[0]) begin
          nxt_st.evMask = axiIn.wdata[NUM_EV-1:0];
        end
      end else if (wrIdx == IDX_SP_HI) begin
        if (axiIn.wstrb[0]) begin
          nxt_st.sp[15:8] = axiIn.wdata[7:0];
        end
      end else if (wrIdx == IDX_SP_LO) begin
        if (axiIn.wstrb[0]) begin
          nxt_st.sp[7:0] = axiIn.wdata[7:0];
        end
      end else if (wrIdx != 16'hFFFE && wrIdx != IDX_UPPER_FLAGS) begin
        nxt_st.axi.bresp = RESP_SLVERR;
      end
    end

    if (axiIn.arvalid && !st_ff.axi.arready && !st_ff.axi.rvalid) begin
      nxt_st.axi.arready = 1'b1;
    end
    if (st_ff.axi.rvalid && axiIn.rready) begin
      nxt_st.axi.rvalid = 1'b0;
    end
    if (st_ff.axi.arready) begin
      rb = readByte(st_ff, rdIdx);
      nxt_st.axi.rvalid = 1'b1;
      nxt_st.axi.rdata = {24'h000000, rb[7:0]};
      nxt_st.axi.rresp = rb[8] ? RESP_SLVERR : RESP_OKAY;
    end

    case (st_ff.eng)
      ENG_IDLE: begin
        if (engBlocked) begin
          nxt_st.eng = ENG_IDLE;
        end else if (cpuIn.intReq || cpuIn.trapReq) begin
          // Upper index byte left out of the frame
          nxt_st.pushQueue = {cpuIn.ccr, cpuIn.a, cpuIn.x, cpuIn.pc[15:8], cpuIn.pc[7:0]};
          nxt_st.pushCnt = INT_STACK_BYTES;
          nxt_st.intEntry = 1'b1;
          nxt_st.trap = cpuIn.trapReq;
          nxt_st.eng = ENG_PUSH;
        end else if (cpuIn.callReq) begin
          nxt_st.pushQueue = {24'h000000, cpuIn.pc[15:8], cpuIn.pc[7:0]};
          nxt_st.pushCnt = CALL_STACK_BYTES;
          nxt_st.intEntry = 1'b0;
          nxt_st.eng = ENG_PUSH;
        end else if (cpuIn.pullReq) begin
          nxt_st.sp = pullAddr;
          nxt_st.cpu.pullValid = 1'b1;
          if (inRam(pullAddr)) begin
            nxt_st.cpu.pullData = st_ff.ram[ramIdx(pullAddr)];
          end else begin
            nxt_st.cpu.pullData = 8'h00;
            evSet[EV_STACK_FAULT] = 1'b1;
          end
        end
      end
      ENG_PUSH: begin
        if (inRam(st_ff.sp)) begin
          nxt_st.ram[ramIdx(st_ff.sp)] = st_ff.pushQueue[0];
        end else begin
          // Stack outside RAM loses the byte; flagged, not fixed
          evSet[EV_STACK_FAULT] = 1'b1;
        end
        nxt_st.sp = st_ff.sp - 16'h0001;
        nxt_st.pushQueue = {8'h00, st_ff.pushQueue[4:1]};
        nxt_st.pushCnt = st_ff.pushCnt - 3'd1;
        if (st_ff.pushCnt == 3'd1) begin
          nxt_st.eng = st_ff.intEntry ? ENG_VEC : ENG_IDLE;
        end
      end
      ENG_VEC: begin
        // Later entries outrank earlier ones
        if (!st_ff.trap) begin
          for (int i = 0; i < NUM_FLAGS; i++) begin
            if (pendEntry[i]) begin
              k = 5'(i);
            end
          end
        end
        nxt_st.cpu.vecValid = 1'b1;
        nxt_st.cpu.vecAddr = VEC_ADDR[k];
        nxt_st.cpu.vecData = vecValue(st_ff, k);
        evSet[EV_ENTRY_DONE] = 1'b1;
        nxt_st.eng = ENG_IDLE;
      end
      default: begin
        nxt_st.eng = ENG_IDLE;
      end
    endcase

    // Hardware set beats a same-cycle clear
    nxt_st.evStatus = (st_ff.evStatus & ~evClr) | evSet;
    nxt_st.irq = |(nxt_st.evStatus & nxt_st.evMask);
    nxt_st.cpu.busy = (nxt_st.eng != ENG_IDLE);
  end

  always_ff @(posedge clk_sys or negedge rstnSync_ff) begin
    if (!rstnSync_ff) begin
      st_ff <= '0;
      st_ff.sp <= SP_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign axiOut = st_ff.axi;
  assign cpuOut = st_ff.cpu;
  assign irq = st_ff.irq;
  assign watchdogExpired = st_ff.wdogExpired;

  // ==========================================================
  // Checks
  spReset_a: assert property (@(posedge clk_sys) $rose(rstnSync_ff) |-> st_ff.sp == SP_RESET)
    else $error("stack pointer not at reset value");
  intFrame_a: assert property (@(posedge clk_sys) disable iff (!rstnSync_ff)
    (st_ff.eng == ENG_IDLE && !engBlocked && cpuIn.intReq) |=>
      st_ff.pushCnt == 3'd5 ##5 (st_ff.eng == ENG_VEC && st_ff.sp == $past(st_ff.sp, 5) - 16'd5))
    else $error("interrupt entry did not stack five bytes");
  noUpperIdx_a: assert property (@(posedge clk_sys) disable iff (!rstnSync_ff)
    (st_ff.eng == ENG_IDLE && !engBlocked && cpuIn.intReq) |=>
      (st_ff.pushQueue[2] == $past(cpuIn.x) && st_ff.pushQueue[4] == $past(cpuIn.ccr)))
    else $error("interrupt frame content wrong");
  callFrame_a: assert property (@(posedge clk_sys) disable iff (!rstnSync_ff)
    (st_ff.eng == ENG_IDLE && !engBlocked && !cpuIn.intReq && !cpuIn.trapReq && cpuIn.callReq) |=>
      ##2 (st_ff.eng == ENG_IDLE && st_ff.sp == $past(st_ff.sp, 2) - 16'd2))
    else $error("call did not stack two bytes");
  pullStep_a: assert property (@(posedge clk_sys) disable iff (!rstnSync_ff)
    st_ff.cpu.pullValid |-> st_ff.sp == $past(st_ff.sp) + 16'd1)
    else $error("pull did not raise stack pointer");
  rtcVector_a: assert property (@(posedge clk_sys) disable iff (!rstnSync_ff)
    (st_ff.eng == ENG_VEC && !st_ff.trap && cpuIn.flags == 17'h10000) |=>
      (st_ff.cpu.vecValid && st_ff.cpu.vecAddr == 16'hFFDA))
    else $error("clock-tick vector address wrong");
  adcVector_a: assert property (@(posedge clk_sys) disable iff (!rstnSync_ff)
    (st_ff.eng == ENG_VEC && !st_ff.trap && cpuIn.flags[16:15] == 2'b11 && cpuIn.flags[14:0] == '0) |=>
      st_ff.cpu.vecAddr == 16'hFFDC)
    else $error("converter vector priority wrong");
  wdogClear_a: assert property (@(posedge clk_sys) disable iff (!rstnSync_ff)
    (st_ff.axi.awready && wrIdx == WDOG_ALIAS) |=> st_ff.wdogCount == '0)
    else $error("watchdog not cleared by write");
  aliasRead_a: assert property (@(posedge clk_sys) disable iff (!rstnSync_ff)
    (st_ff.axi.arready && rdIdx == WDOG_ALIAS) |=>
      (st_ff.axi.rvalid && st_ff.axi.rdata == {24'h000000, RESET_VECTOR[7:0]}))
    else $error("alias read not reset vector low byte");
  upperFlags_a: assert property (@(posedge clk_sys) disable iff (!rstnSync_ff)
    (st_ff.axi.arready && rdIdx == IDX_UPPER_FLAGS) |=>
      st_ff.axi.rdata == {29'h0, $past(cpuIn.flags[16:14], 2)})
    else $error("upper flag register wrong");
  // Top of page zero must be a real RAM cell, not a hole
  page0Ram_a: assert property (@(posedge clk_sys) disable iff (!rstnSync_ff)
    (st_ff.axi.awready && wrIdx == PAGE0_END && axiIn.wstrb[0]) |=>
      st_ff.ram[ramIdx(PAGE0_END)] == $past(axiIn.wdata[7:0]))
    else $error("page zero RAM top not writable");

  entryCov_c: cover property (@(posedge clk_sys) disable iff (!rstnSync_ff) st_ff.cpu.vecValid && !st_ff.trap);
  callCov_c: cover property (@(posedge clk_sys) disable iff (!rstnSync_ff)
    st_ff.eng == ENG_PUSH && !st_ff.intEntry ##2 st_ff.eng == ENG_IDLE);
  pullCov_c: cover property (@(posedge clk_sys) disable iff (!rstnSync_ff) st_ff.cpu.pullValid);
  irqCov_c: cover property (@(posedge clk_sys) disable iff (!rstnSync_ff) $rose(st_ff.irq));

endmodule

//--- dv/cpu_core_model.sv
`timescale 1ns/1ps
module cpu_core_model (
  input wire logic clk_sys,
  input vec_stack_pkg::cpuOut_t cpuOut,
  output vec_stack_pkg::cpuIn_t cpuIn
);
  import vec_stack_pkg::*;

  initial begin
    cpuIn = '0;
  end

  task automatic set_flags(input logic [NUM_FLAGS-1:0] f);
    @(posedge clk_sys);
    cpuIn.flags <= f;
  endtask

  // ==========
  // Requests: kind 0 interrupt, 1 trap, 2 call, 3 pull
  task automatic req(input int kind, input logic [15:0] pc, input logic [7:0] x, input logic [7:0] a,
      input logic [7:0] ccr, output logic [15:0] vAddr, output logic [15:0] vData, output logic [7:0] pData);
    int n;
    logic seenBusy;
    logic done;
    n = 0;
    seenBusy = 1'b0;
    done = 1'b0;
    @(posedge clk_sys);
    // Caller has left the stack pointer inside RAM, except in the stack fault pull
    cpuIn.intReq <= (kind == 0);
    cpuIn.trapReq <= (kind == 1);
    cpuIn.callReq <= (kind == 2);
    cpuIn.pullReq <= (kind == 3);
    cpuIn.pc <= pc;
    cpuIn.x <= x;
    cpuIn.a <= a;
    cpuIn.ccr <= ccr;
    // Engine is idle here, so one edge suffices; a held pull would repeat
    @(posedge clk_sys);
    cpuIn.intReq <= 1'b0;
    cpuIn.trapReq <= 1'b0;
    cpuIn.callReq <= 1'b0;
    cpuIn.pullReq <= 1'b0;
    // Released operands turn over so stale values cannot pass
    cpuIn.pc <= ~pc;
    cpuIn.x <= ~x;
    cpuIn.a <= ~a;
    cpuIn.ccr <= ~ccr;
    while (!done && n < 50) begin
      @(posedge clk_sys);
      n++;
      vAddr = cpuOut.vecAddr;
      vData = cpuOut.vecData;
      pData = cpuOut.pullData;
      done = cpuOut.vecValid || cpuOut.pullValid || (seenBusy && !cpuOut.busy);
      seenBusy = seenBusy || cpuOut.busy;
    end
    // No answer in time: unknown results fail every compare
    if (!done) begin
      vAddr = 'x;
      vData = 'x;
      pData = 'x;
    end
  endtask
endmodule

//--- dv/vector_table_and_stack_ram_bench.sv
`timescale 1ns/1ps
module vector_table_and_stack_ram_bench;
  import vec_stack_pkg::*;

  localparam int WDOG_SIM = 64;
  logic clk_sys = 1'b0;
  logic resetn;
  axiIn_t axiIn;
  axiOut_t axiOut;
  cpuIn_t cpuIn;
  cpuOut_t cpuOut;
  logic irq;
  logic watchdogExpired;
  int errCount = 0;
  int nCompared = 0;
  int wdogPulses = 0;
  int n;
  int p0;
  logic [1:0] resp;
  logic [31:0] rdata;
  logic [15:0] vAddr;
  logic [15:0] vData;
  logic [7:0] pData;
  logic [7:0] stk [5] = '{8'h34, 8'h12, 8'h56, 8'h78, 8'h9A};

  vector_stack_unit #(.WDOG_CYCLES(WDOG_SIM)) u_dut (.clk_sys(clk_sys), .resetn(resetn), .axiIn(axiIn),
    .axiOut(axiOut), .cpuIn(cpuIn), .cpuOut(cpuOut), .irq(irq), .watchdogExpired(watchdogExpired));
  cpu_core_model u_cpu (.clk_sys(clk_sys), .cpuOut(cpuOut), .cpuIn(cpuIn));

  always #5 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    if (watchdogExpired === 1'b1) wdogPulses <= wdogPulses + 1;
  end

  // ==========
  // Bus and compare helpers
  task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
    nCompared++;
    if (seen !== exp) begin
      errCount++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic axi_wr(input logic [15:0] idx, input logic [7:0] data);
    int k;
    k = 0;
    @(posedge clk_sys);
    axiIn.awaddr <= {idx, 2'b00};
    axiIn.wdata <= {24'h000000, data};
    axiIn.wstrb <= 4'hF;
    axiIn.awvalid <= 1'b1;
    axiIn.wvalid <= 1'b1;
    axiIn.bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      k++;
      if (axiOut.awready === 1'b1) axiIn.awvalid <= 1'b0;
      if (axiOut.wready === 1'b1) axiIn.wvalid <= 1'b0;
    end while (axiOut.bvalid !== 1'b1 && k < 100);
    resp = axiOut.bresp;
    axiIn.bready <= 1'b0;
    if (k >= 100) errCount++;
  endtask

  task automatic axi_rd(input logic [15:0] idx);
    int k;
    k = 0;
    @(posedge clk_sys);
    axiIn.araddr <= {idx, 2'b00};
    axiIn.arvalid <= 1'b1;
    axiIn.rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      k++;
      if (axiOut.arready === 1'b1) axiIn.arvalid <= 1'b0;
    end while (axiOut.rvalid !== 1'b1 && k < 100);
    rdata = axiOut.rdata;
    resp = axiOut.rresp;
    axiIn.rready <= 1'b0;
    if (k >= 100) errCount++;
  endtask

  task automatic rchk(input logic [15:0] idx, input logic [7:0] exp, input string what);
    axi_rd(idx);
    check(what, {resp, rdata}, {RESP_OKAY, 24'h000000, exp});
  endtask

  task automatic wchk(input logic [15:0] idx, input logic [7:0] data);
    axi_wr(idx, data);
    check("write response", resp, RESP_OKAY);
  endtask

  function automatic logic [7:0] vbyte(input logic [15:0] a);
    return a[7:0] ^ 8'h3C;
  endfunction

  task automatic int_chk(input logic [16:0] f, input int kind, input logic [15:0] ea);
    u_cpu.set_flags(f);
    u_cpu.req(kind, 16'h1234, 8'h56, 8'h78, 8'h9A, vAddr, vData, pData);
    check("vector address", vAddr, ea);
    check("vector data", vData, {vbyte(ea), vbyte(ea + 16'h0001)});
  endtask

  task automatic final_report();
    $display("compared %0d mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Tests need under 1000 cycles; allow 10000 (100 us at 10 ns)
  initial begin
    #100000;
    errCount++;
    final_report();
  end

  // ==========
  // Test sequence
  initial begin
    resetn = 1'b0;
    axiIn = '0;
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rchk(IDX_SP_HI, 8'h00, "sp high at reset");
    rchk(IDX_SP_LO, 8'hFF, "sp low at reset");
    rchk(IDX_UPPER_FLAGS, 8'h00, "upper flags at reset");
    rchk(16'hFFFF, RESET_VECTOR[7:0], "alias read");
    wchk(16'hFFFF, 8'h5A);
    rchk(16'hFFFF, RESET_VECTOR[7:0], "alias after write");
    $display("test reset done");
    wchk(16'h0060, 8'h11);
    wchk(16'h025F, 8'h22);
    wchk(16'h00FF, 8'h33);
    rchk(16'h0060, 8'h11, "ram first");
    rchk(16'h025F, 8'h22, "ram last");
    rchk(16'h00FF, 8'h33, "page zero top");
    axi_wr(16'h0260, 8'h44);
    check("beyond ram", resp, RESP_SLVERR);
    axi_rd(16'h005F);
    check("below ram", resp, RESP_SLVERR);
    $display("test ram done");
    u_cpu.set_flags(17'h14000);
    repeat (3) @(posedge clk_sys);
    rchk(IDX_UPPER_FLAGS, 8'h05, "flags 17 and 15");
    u_cpu.set_flags(17'h0BFFF);
    wchk(IDX_UPPER_FLAGS, 8'hFF);
    rchk(IDX_UPPER_FLAGS, 8'h02, "flag 16 only");
    $display("test flags done");
    for (int i = 0; i < 36; i++) wchk(16'hFFDA + 16'(i), vbyte(16'hFFDA + 16'(i)));
    for (int f = 1; f <= 17; f++) int_chk(17'(1) << (f - 1), 0, 16'hFFFC - 16'(2 * f));
    int_chk(17'h1FFFF, 0, 16'hFFFA);
    int_chk(17'h18000, 0, 16'hFFDC);
    int_chk(17'h1FFFF, 1, 16'hFFFC);
    $display("test vectors done");
    u_cpu.set_flags(17'h00000);
    wchk(IDX_SP_HI, 8'h01);
    wchk(IDX_SP_LO, 8'h00);
    wchk(16'h00FB, 8'hEE);
    u_cpu.req(0, 16'h1234, 8'h56, 8'h78, 8'h9A, vAddr, vData, pData);
    for (int i = 0; i < 5; i++) rchk(16'h0100 - 16'(i), stk[i], "stacked byte");
    rchk(16'h00FB, 8'hEE, "upper index kept out");
    rchk(IDX_SP_HI, 8'h00, "sp high after entry");
    rchk(IDX_SP_LO, 8'hFB, "sp low after entry");
    for (int i = 4; i >= 0; i--) begin
      u_cpu.req(3, 16'h0000, 8'h00, 8'h00, 8'h00, vAddr, vData, pData);
      check("pulled byte", pData, stk[i]);
    end
    rchk(IDX_SP_HI, 8'h01, "sp high after pulls");
    rchk(IDX_SP_LO, 8'h00, "sp low after pulls");
    u_cpu.req(2, 16'hBEEF, 8'h00, 8'h00, 8'h00, vAddr, vData, pData);
    rchk(16'h0100, 8'hEF, "return low");
    rchk(16'h00FF, 8'hBE, "return high");
    rchk(IDX_SP_LO, 8'hFE, "sp after call");
    $display("test stack done");
    wchk(IDX_EV_MASK, 8'h01);
    wchk(16'hFFFF, 8'h00);
    wchk(IDX_EV_STATUS, 8'h07);
    p0 = wdogPulses;
    repeat (20) wchk(16'hFFFF, 8'hA5);
    check("kicked watchdog", wdogPulses - p0, 0);
    check("irq while kicked", irq, 1'b0);
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (watchdogExpired !== 1'b1 && n < 200);
    check("watchdog period", n > WDOG_SIM - 10 && n <= WDOG_SIM + 2, 1'b1);
    repeat (2) @(posedge clk_sys);
    check("irq on wrap", irq, 1'b1);
    rchk(IDX_EV_STATUS, 8'h01, "status wrap");
    wchk(IDX_EV_MASK, 8'h04);
    repeat (2) @(posedge clk_sys);
    check("irq masked", irq, 1'b0);
    wchk(IDX_EV_STATUS, 8'h01);
    rchk(IDX_EV_STATUS, 8'h00, "status cleared");
    u_cpu.req(0, 16'h1234, 8'h56, 8'h78, 8'h9A, vAddr, vData, pData);
    repeat (2) @(posedge clk_sys);
    check("irq on entry", irq, 1'b1);
    rchk(IDX_EV_STATUS, 8'h04, "status entry");
    $display("test events done");
    wchk(16'hFFFF, 8'h00);
    wchk(IDX_SP_HI, 8'h10);
    wchk(IDX_EV_STATUS, 8'h07);
    u_cpu.req(3, 16'h0000, 8'h00, 8'h00, 8'h00, vAddr, vData, pData);
    check("pull outside ram", pData, 8'h00);
    rchk(IDX_EV_STATUS, 8'h02, "status stack fault");
    rchk(IDX_EV_MASK, 8'h04, "mask readback");
    $display("test stack fault done");
    final_report();
  end
endmodule
